// ==== sdtm_core.sv ====
// Command decoder, mode setting, bank tracking and burst data path of the DRAM device.
module sdtm_core #(
  parameter int DQ_W = 16,
  parameter int ROW_KEEP = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Command, address and mask pins
  input wire logic cke_i,
  input wire logic cs_b_i,
  input wire logic ras_b_i,
  input wire logic cas_b_i,
  input wire logic we_b_i,
  input wire logic bank_select_low_i,
  input wire logic bank_select_high_i,
  input wire logic [sdtm_pkg::ROW_W-1:0] row_address_bits_i,
  input wire logic dqm_i,
  // Data pins
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  // Status
  output logic [sdtm_pkg::MODE_W-1:0] operating_mode_setup_o,
  output logic mode_loaded_o,
  output logic [sdtm_pkg::BANKS-1:0] bank_open_o,
  output logic write_buf_ready_o
);
  localparam int COL_W = (DQ_W == 16) ? 9 : 10;
  localparam int MEM_AW = 2 + ROW_KEEP + COL_W;
  localparam int WB_W = MEM_AW + DQ_W;

  if (!(DQ_W == 8 || DQ_W == 16) || ROW_KEEP < 1 || ROW_KEEP > sdtm_pkg::ROW_W) begin : g_chk
    $error("sdtm_core: DQ_W must be 8 or 16 and ROW_KEEP 1 to 12");
  end

  // Block mask of a burst; full page covers the whole row.
  function automatic logic [COL_W-1:0] blk_mask(input logic [2:0] code);
    unique case (code)
      sdtm_pkg::BL_ONE: blk_mask = '0;
      sdtm_pkg::BL_TWO: blk_mask = COL_W'(1);
      sdtm_pkg::BL_FOUR: blk_mask = COL_W'(3);
      sdtm_pkg::BL_EIGHT: blk_mask = COL_W'(7);
      default: blk_mask = '1;
    endcase
  endfunction : blk_mask

  // Legal length codes; the reserved ones block column commands.
  function automatic logic bl_legal(input logic [2:0] code, input logic inter);
    bl_legal = (code <= sdtm_pkg::BL_EIGHT) || (code == sdtm_pkg::BL_PAGE && !inter);
  endfunction : bl_legal

  sdtm_pkg::sdtm_cmd_e cmd;
  sdtm_pkg::sdtm_eng_e state, next_state;
  logic [1:0] bank;
  logic [COL_W-1:0] col_in;
  logic [sdtm_pkg::MODE_W-1:0] mode, next_mode;
  logic loaded, next_loaded;
  logic [sdtm_pkg::BANKS-1:0] open, next_open;
  logic [ROW_KEEP-1:0] row [sdtm_pkg::BANKS];
  logic [ROW_KEEP-1:0] next_row [sdtm_pkg::BANKS];
  logic [1:0] bkt, next_bkt;
  logic [COL_W-1:0] start, next_start, ofs, next_ofs, mask, next_mask;
  logic full, next_full, ap, next_ap, inter, next_inter;
  logic cl3, col_ok, col_go, stop, last;
  logic [COL_W-1:0] acc_col, cmd_mask;
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic [DQ_W-1:0] rd_word, p1_data, next_p1_data, next_dq;
  logic p1_valid, next_p1_valid, dqm_d1, next_oe;
  logic wb_in_valid, wb_out_valid, wb_out_ready;
  logic [WB_W-1:0] wb_in_data, wb_out_data;

  // A deselected chip or a held clock enable turns the edge into a no-operation.
  assign cmd = (cs_b_i || !cke_i) ? sdtm_pkg::CMD_NOP
             : sdtm_pkg::sdtm_cmd_e'({ras_b_i, cas_b_i, we_b_i});
  assign bank = {bank_select_high_i, bank_select_low_i};
  assign col_in = row_address_bits_i[COL_W-1:0];
  // Mode fields decoded; unsupported latency or test modes block all column commands.
  assign cl3 = mode[sdtm_pkg::CL_MSB:sdtm_pkg::CL_LSB] == sdtm_pkg::CL_THREE;
  assign col_ok = loaded
    && (cl3 || mode[sdtm_pkg::CL_MSB:sdtm_pkg::CL_LSB] == sdtm_pkg::CL_TWO)
    && mode[sdtm_pkg::OPM_MSB:sdtm_pkg::OPM_LSB] == sdtm_pkg::OPM_NORMAL
    && bl_legal(mode[sdtm_pkg::BL_MSB:sdtm_pkg::BL_LSB], mode[sdtm_pkg::ORDER_BIT]);
  assign col_go = col_ok && open[bank] && (cmd == sdtm_pkg::CMD_RD || cmd == sdtm_pkg::CMD_WR);
  // A stop, or a precharge aimed at the burst's bank, ends the burst at this edge.
  assign stop = cmd == sdtm_pkg::CMD_BST || (cmd == sdtm_pkg::CMD_PRE
    && (row_address_bits_i[sdtm_pkg::AUTO_PRE_BIT] || bank == bkt));
  assign last = !full && ofs == mask;
  // Burst column stays inside its aligned block, counting up or interleaving.
  assign acc_col = (start & ~mask)
    | ((inter ? (start ^ ofs) : (start + ofs)) & mask);
  assign cmd_mask = (cmd == sdtm_pkg::CMD_WR && mode[sdtm_pkg::SINGLE_WR_BIT]) ? '0
    : blk_mask(mode[sdtm_pkg::BL_MSB:sdtm_pkg::BL_LSB]);
  assign rd_word = mem[{bkt, row[bkt], acc_col}];

  // Engine, bank and mode next values; commands of this edge override the burst step.
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_loaded = loaded;
    next_open = open;
    next_row = row;
    next_bkt = bkt;
    next_start = start;
    next_ofs = ofs + COL_W'(1);
    next_mask = mask;
    next_full = full;
    next_ap = ap;
    next_inter = inter;
    if (state != sdtm_pkg::ENG_IDLE && last) begin
      // Auto-precharge starts as the last word leaves the array.
      next_state = sdtm_pkg::ENG_IDLE;
      if (ap) begin
        next_open[bkt] = 1'b0;
      end
    end
    if (stop) begin
      next_state = sdtm_pkg::ENG_IDLE;
    end
    unique case (cmd)
      sdtm_pkg::CMD_ACT: begin
        next_open[bank] = 1'b1;
        next_row[bank] = row_address_bits_i[ROW_KEEP-1:0];
      end
      sdtm_pkg::CMD_PRE: begin
        if (row_address_bits_i[sdtm_pkg::AUTO_PRE_BIT]) begin
          next_open = '0;
        end else begin
          next_open[bank] = 1'b0;
        end
      end
      sdtm_pkg::CMD_LMR: begin
        // A load with any bank open is dropped, so the setting stays defined.
        if (open == '0) begin
          next_mode = row_address_bits_i;
          next_loaded = 1'b1;
        end
      end
      sdtm_pkg::CMD_RD, sdtm_pkg::CMD_WR: begin
        if (col_go) begin
          next_bkt = bank;
          next_start = col_in;
          next_mask = cmd_mask;
          next_full = cmd_mask == '1 && cmd == sdtm_pkg::CMD_RD
            || cmd_mask == '1 && !mode[sdtm_pkg::SINGLE_WR_BIT];
          next_ap = row_address_bits_i[sdtm_pkg::AUTO_PRE_BIT];
          next_inter = mode[sdtm_pkg::ORDER_BIT];
          next_ofs = (cmd == sdtm_pkg::CMD_RD) ? '0 : COL_W'(1);
          next_state = (cmd == sdtm_pkg::CMD_RD) ? sdtm_pkg::ENG_READ : sdtm_pkg::ENG_WRITE;
          if (cmd == sdtm_pkg::CMD_WR && cmd_mask == '0) begin
            next_state = sdtm_pkg::ENG_IDLE;
            if (row_address_bits_i[sdtm_pkg::AUTO_PRE_BIT]) begin
              next_open[bank] = 1'b0;
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  // Write words: the command's own word, then burst words; mask and stops block same cycle.
  always_comb begin
    wb_in_valid = 1'b0;
    wb_in_data = {bkt, row[bkt], acc_col, dq_i};
    if (col_go && cmd == sdtm_pkg::CMD_WR) begin
      wb_in_valid = !dqm_i;
      wb_in_data = {bank, row[bank], col_in, dq_i};
    end else if (state == sdtm_pkg::ENG_WRITE && !stop && !col_go) begin
      wb_in_valid = !dqm_i;
    end
  end

  // Refresh holds the array for a cycle; the pair buffer absorbs the stalled word.
  assign wb_out_ready = cmd != sdtm_pkg::CMD_REF;

  sdtm_pair_buf #(.W(WB_W)) u_wbuf (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(wb_in_valid),
    .in_ready_o(write_buf_ready_o),
    .in_data_i(wb_in_data),
    .out_valid_o(wb_out_valid),
    .out_ready_i(wb_out_ready),
    .out_data_o(wb_out_data)
  );

  // Read path: latency three adds one stage; the mask acts two edges after sampling.
  always_comb begin
    next_p1_data = rd_word;
    next_p1_valid = state == sdtm_pkg::ENG_READ;
    next_dq = cl3 ? p1_data : rd_word;
    next_oe = (cl3 ? p1_valid : state == sdtm_pkg::ENG_READ) && !dqm_d1;
  end

  // Registers only.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state <= sdtm_pkg::ENG_IDLE;
      mode <= sdtm_pkg::MODE_RESET;
      loaded <= 1'b0;
      open <= '0;
      row <= '{default: '0};
      bkt <= 2'h0;
      start <= '0;
      ofs <= '0;
      mask <= '0;
      full <= 1'b0;
      ap <= 1'b0;
      inter <= 1'b0;
      p1_data <= '0;
      p1_valid <= 1'b0;
      dqm_d1 <= 1'b1;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      loaded <= next_loaded;
      open <= next_open;
      row <= next_row;
      bkt <= next_bkt;
      start <= next_start;
      ofs <= next_ofs;
      mask <= next_mask;
      full <= next_full;
      ap <= next_ap;
      inter <= next_inter;
      p1_data <= next_p1_data;
      p1_valid <= next_p1_valid;
      dqm_d1 <= dqm_i;
      dq_o <= next_dq;
      dq_oe_o <= next_oe;
    end
  end

  // Array contents are storage only and need no reset.
  always_ff @(posedge ref_clk_i) begin
    if (wb_out_valid && wb_out_ready) begin
      mem[wb_out_data[WB_W-1:DQ_W]] <= wb_out_data[DQ_W-1:0];
    end
  end

  assign operating_mode_setup_o = mode;
  assign mode_loaded_o = loaded;
  assign bank_open_o = open;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_rd3;
    cmd == sdtm_pkg::CMD_RD && col_go && cl3 ##1 !dqm_i;
  endsequence
  sequence s_bst3;
    cmd == sdtm_pkg::CMD_BST && cl3 ##1 cmd != sdtm_pkg::CMD_RD;
  endsequence

  AST_DESELECT_NOP: assert property (cs_b_i |=> $stable(operating_mode_setup_o))
    else $error("deselected edge changed the mode setting");
  AST_RD_CL3_DRIVE: assert property (s_rd3 |=> ##1 dq_oe_o)
    else $error("latency three read not driven");
  AST_RD_CL2_DRIVE: assert property (cmd == sdtm_pkg::CMD_RD && col_go && !cl3 && !dqm_i
    |=> ##1 dq_oe_o)
    else $error("latency two read not driven");
  AST_BST_FLOAT3: assert property (s_bst3 |=> ##1 !dq_oe_o)
    else $error("outputs still driven after burst stop");
  AST_PRE_FLOAT2: assert property (cmd == sdtm_pkg::CMD_PRE && !cl3
    && row_address_bits_i[sdtm_pkg::AUTO_PRE_BIT] |=> ##1 !dq_oe_o)
    else $error("outputs still driven after precharge");
  AST_WR_STOP_DROP: assert property (state == sdtm_pkg::ENG_WRITE && stop
    |-> !wb_in_valid)
    else $error("write word taken in stop cycle");
  AST_WR_PRE_DROP: assert property (state == sdtm_pkg::ENG_WRITE
    && cmd == sdtm_pkg::CMD_PRE && bank == bkt |-> !wb_in_valid)
    else $error("write word taken in precharge cycle");
  AST_WR_MASK: assert property (dqm_i |-> !wb_in_valid)
    else $error("masked write word taken");
  AST_RD_MASK: assert property (dqm_i |=> ##1 !dq_oe_o)
    else $error("masked read word driven");
  AST_AUTO_PRE: assert property (state == sdtm_pkg::ENG_READ && last && ap && !stop
    && cmd != sdtm_pkg::CMD_ACT |=> !bank_open_o[$past(bkt)])
    else $error("read auto-precharge did not close bank");
  AST_LMR_LOAD: assert property (cmd == sdtm_pkg::CMD_LMR && open == '0
    |=> mode_loaded_o && operating_mode_setup_o == $past(row_address_bits_i))
    else $error("mode load not stored");
  AST_LMR_OPEN: assert property (cmd == sdtm_pkg::CMD_LMR && open != '0
    |=> $stable(operating_mode_setup_o))
    else $error("mode load taken with a bank open");
  AST_ACT_OPEN: assert property (cmd == sdtm_pkg::CMD_ACT
    |=> bank_open_o[$past(bank)])
    else $error("activate did not open bank");
  AST_NO_MODE_IDLE: assert property (!mode_loaded_o |-> !dq_oe_o)
    else $error("output driven before mode load");
  AST_COL_EACH: assert property (cmd == sdtm_pkg::CMD_RD && col_go
    |=> state == sdtm_pkg::ENG_READ && ofs == '0)
    else $error("read command not accepted");
endmodule : sdtm_core

// ==== sdtm_pkg.sv ====
// Shared constants, field layout and types of the synchronous DRAM command block.
// Function
// - Column commands may come every cycle and each one is accepted.
// - Burst stop during a read floats outputs after the read latency.
// - Burst stop during a write ignores the same-cycle input word.
// - Precharge during a read floats outputs after the read latency.
// - Precharge during a write makes the same-cycle input word invalid.
// - Read auto-precharge starts latency minus one cycles before the last word.
// - Mask blocks read output two cycles later and write input immediately.
// - Activate takes bank and 12-bit row; column commands take 9 or 10 column bits.
// - Mode setting has no default; column commands need a prior mode load.
// - Mode word: length 0-2, order 3, latency 4-6, op mode 7-8, single write 9.
// - Mode setting changes only by the load command and is kept otherwise.
// - First read word is driven one edge before the latency edge.
// - With the single-write bit set, writes touch one location, reads still burst.
// - Bursts wrap inside an aligned block of their length; full page wraps in page.
// - Only an all-zero operating mode field counts as normal operation.
package sdtm_pkg;
  localparam int ROW_W = 12;
  localparam int MODE_W = 12;
  localparam int BANKS = 4;
  localparam int AUTO_PRE_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int ORDER_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int CL_MSB = 6;
  localparam int OPM_LSB = 7;
  localparam int OPM_MSB = 8;
  localparam int SINGLE_WR_BIT = 9;
  localparam logic [2:0] CL_TWO = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [2:0] BL_ONE = 3'h0;
  localparam logic [2:0] BL_TWO = 3'h1;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  // Mask-to-output delay on reads; write mask and stop delays are zero.
  localparam int MASK_TO_OUTPUT_DELAY = 2;
  // Command code is the row, column and write strobes, all active low.
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
  } sdtm_cmd_e;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0, ENG_READ = 2'h1, ENG_WRITE = 2'h3
  } sdtm_eng_e;
endpackage : sdtm_pkg

// ==== sdtm_pair_buf.sv ====
// Two-entry valid/ready buffer for write words heading into the array.
module sdtm_pair_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] slot [2];
  logic [1:0] count;
  logic [1:0] next_count;
  logic [W-1:0] next_slot0;
  logic [W-1:0] next_slot1;
  logic push;
  logic pop;

  // Ready and valid follow the fill count directly.
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = slot[0];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Slot 0 is always the oldest word, so the drain side never needs a pointer.
  always_comb begin
    next_count = count;
    next_slot0 = slot[0];
    next_slot1 = slot[1];
    if (push && !pop) begin
      next_count = count + 2'h1;
      if (count == 2'h0) begin
        next_slot0 = in_data_i;
      end else begin
        next_slot1 = in_data_i;
      end
    end else if (pop && !push) begin
      next_count = count - 2'h1;
      next_slot0 = slot[1];
    end else if (pop && push) begin
      next_slot0 = (count == 2'h1) ? in_data_i : slot[1];
      next_slot1 = in_data_i;
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      count <= 2'h0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else begin
      count <= next_count;
      slot[0] <= next_slot0;
      slot[1] <= next_slot1;
    end
  end
endmodule : sdtm_pair_buf

// ==== sdtm_ctrl_model.sv ====
// Behavioural memory controller that drives the command, address, mask and write data pins.
module sdtm_ctrl_model #(
  parameter int POWERUP_CYC = 12500,
  parameter int SLACK = 0
) (
  // Clock
  input wire logic ref_clk_i,
  // Command and address pins
  output logic cke_o,
  output logic cs_b_o,
  output logic ras_b_o,
  output logic cas_b_o,
  output logic we_b_o,
  output logic bank_select_low_o,
  output logic bank_select_high_o,
  output logic [11:0] row_address_bits_o,
  // Mask and write data
  output logic dqm_o,
  output logic [15:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycle counts of the faster grades at the 8 ns clock.
  localparam int T_RCD = 3;
  localparam int T_RC = 10;
  localparam int T_RAS = 7;
  localparam int T_RP = 3;
  localparam int T_MRD = 2;
  // When set, commands go out with chip select high so the device must see no-operations.
  logic cs_off;
  // When set, commands go out with the clock enable low, which the device treats as idle.
  logic cke_off;

  // Pins start idle with the mask high, as power-up asks.
  initial begin
    cs_off = 1'b0;
    cke_off = 1'b0;
    cke_o = 1'b1;
    cs_b_o = 1'b1;
    {ras_b_o, cas_b_o, we_b_o} = 3'h7;
    {bank_select_high_o, bank_select_low_o} = 2'h0;
    row_address_bits_o = 12'h000;
    dqm_o = 1'b1;
    dq_o = 16'h0000;
  end

  // One command per edge; a released data bus toggles so stale words never look valid.
  task automatic cmd(input logic [2:0] op, input logic [1:0] bank, input logic [11:0] addr,
                     input logic dqm, input logic dv, input logic [15:0] data);
    @(posedge ref_clk_i);
    cs_b_o <= cs_off;
    cke_o <= !cke_off;
    {ras_b_o, cas_b_o, we_b_o} <= op;
    {bank_select_high_o, bank_select_low_o} <= bank;
    row_address_bits_o <= addr;
    dqm_o <= dqm;
    dq_o <= dv ? data : ~dq_o;
  endtask : cmd

  task automatic nop(input int n);
    for (int i = 0; i < n; i++) begin
      cmd(sdtm_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 1'b0, 16'h0000);
    end
  endtask : nop

  // Power-up wait with the mask high, precharge of all banks, then two refreshes.
  task automatic init();
    for (int i = 0; i < POWERUP_CYC; i++) begin
      cmd(sdtm_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1, 1'b0, 16'h0000);
    end
    cmd(sdtm_pkg::CMD_PRE, 2'h0, 12'h400, 1'b0, 1'b0, 16'h0000);
    nop(T_RP - 1 + SLACK);
    for (int i = 0; i < 2; i++) begin
      cmd(sdtm_pkg::CMD_REF, 2'h0, 12'h000, 1'b0, 1'b0, 16'h0000);
      nop(T_RC - 1 + SLACK);
    end
  endtask : init

  // Loads are only made with every bank closed, and the next command waits out the gap.
  task automatic load(input logic [11:0] word);
    cmd(sdtm_pkg::CMD_PRE, 2'h0, 12'h400, 1'b0, 1'b0, 16'h0000);
    nop(T_RP - 1 + SLACK);
    cmd(sdtm_pkg::CMD_LMR, 2'h0, word, 1'b0, 1'b0, 16'h0000);
    nop(T_MRD - 1 + SLACK);
  endtask : load

  // The activate-to-column wait also covers the bank-to-bank activate gap.
  task automatic open(input logic [1:0] bank, input logic [11:0] row);
    cmd(sdtm_pkg::CMD_ACT, bank, row, 1'b0, 1'b0, 16'h0000);
    nop(T_RCD - 1 + SLACK);
  endtask : open

  // Waiting the full row time first also covers the data-to-precharge gaps.
  task automatic close();
    nop(T_RAS + SLACK);
    cmd(sdtm_pkg::CMD_PRE, 2'h0, 12'h400, 1'b0, 1'b0, 16'h0000);
    nop(T_RP - 1 + SLACK);
  endtask : close
endmodule : sdtm_ctrl_model

// ==== sdram_timing_init_mode_tb.sv ====
// Self-checking bench of the DRAM command block against a controller model.
module sdram_timing_init_mode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i;
  logic rst_b_i;
  logic cke, cs_b, ras_b, cas_b, we_b, bsl, bsh, dqm, dq_oe, loaded, wbuf_rdy;
  logic [11:0] addr;
  logic [11:0] mode;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic [3:0] bank_open;
  logic [15:0] mem [0:7];
  logic ilv;
  int error_cnt;
  int n_tests;

  sdtm_ctrl_model sdtm_ctrl_model_inst (.ref_clk_i(ref_clk_i), .cke_o(cke), .cs_b_o(cs_b),
    .ras_b_o(ras_b), .cas_b_o(cas_b), .we_b_o(we_b), .bank_select_low_o(bsl),
    .bank_select_high_o(bsh), .row_address_bits_o(addr), .dqm_o(dqm), .dq_o(dq_w));

  sdtm_core #(.DQ_W(16), .ROW_KEEP(1)) sdtm_core_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .cke_i(cke), .cs_b_i(cs_b), .ras_b_i(ras_b), .cas_b_i(cas_b), .we_b_i(we_b),
    .bank_select_low_i(bsl), .bank_select_high_i(bsh), .row_address_bits_i(addr),
    .dqm_i(dqm), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe), .operating_mode_setup_o(mode),
    .mode_loaded_o(loaded), .bank_open_o(bank_open), .write_buf_ready_o(wbuf_rdy));

  // Free-running 125 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Read at latency m and length bl; mi masks one word, sj stops the burst with sop.
  // Every cycle is checked, so early drive, late float and wrong order all show up.
  task automatic rd(input logic [1:0] bank, input logic [2:0] col, input int m, input int bl,
                    input int mi, input int sj, input logic [2:0] sop, input logic ap);
    int nw;
    int w;
    logic [2:0] msk;
    logic [2:0] c;
    nw = (sj >= 0 && sj + 1 < bl) ? sj + 1 : bl;
    msk = 3'(bl - 1);
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_RD, bank, {1'b0, ap, 7'h00, col}, 1'b0, 1'b0, 16'h0);
    for (int j = 0; j <= m - 1 + bl; j++) begin
      sdtm_ctrl_model_inst.cmd((j == sj) ? sop : sdtm_pkg::CMD_NOP, bank, 12'h000,
                               mi >= 0 && j == m - 3 + mi, 1'b0, 16'h0000);
      #1;
      w = j - (m - 1);
      c = ilv ? (col ^ w[2:0]) : ((col & ~msk) | ((col + w[2:0]) & msk));
      if (w >= 0 && w < nw) begin
        chk_flag("read drive", w != mi, dq_oe);
        if (w != mi) chk_word("read word", mem[c], dq_r);
      end else begin
        chk_flag("read idle", 1'b0, dq_oe);
      end
      if (ap && j >= bl - 1 && j <= bl) chk_flag("auto close", j == bl - 1, bank_open[bank]);
    end
  endtask : rd

  // Main sequence: reset, initialization, then mode, write and read scenarios.
  initial begin
    rst_b_i = 1'b0;
    ilv = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk_word("mode at reset", 16'h0000, {4'h0, mode});
    chk_flag("loaded at reset", 1'b0, loaded);
    chk_word("banks at reset", 16'h0000, {12'h000, bank_open});
    chk_flag("oe at reset", 1'b0, dq_oe);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    sdtm_ctrl_model_inst.init();
    sdtm_ctrl_model_inst.load(12'h223);
    #1;
    chk_word("mode word", 16'h0223, {4'h0, mode});
    chk_flag("loaded", 1'b1, loaded);
    // A load with chip select high, one with clock enable low and one with a bank open must all be ignored.
    sdtm_ctrl_model_inst.cs_off = 1'b1;
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_LMR, 2'h0, 12'h032, 1'b0, 1'b0, 16'h0000);
    sdtm_ctrl_model_inst.cs_off = 1'b0;
    sdtm_ctrl_model_inst.nop(2);
    #1;
    chk_word("mode after deselected load", 16'h0223, {4'h0, mode});
    sdtm_ctrl_model_inst.cke_off = 1'b1;
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_LMR, 2'h0, 12'h032, 1'b0, 1'b0, 16'h0000);
    sdtm_ctrl_model_inst.cke_off = 1'b0;
    sdtm_ctrl_model_inst.nop(2);
    #1;
    chk_word("mode after clock-held load", 16'h0223, {4'h0, mode});
    sdtm_ctrl_model_inst.open(2'h0, 12'h005);
    sdtm_ctrl_model_inst.open(2'h3, 12'h005);
    #1;
    chk_word("open banks", 16'h0009, {12'h000, bank_open});
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_LMR, 2'h0, 12'h032, 1'b0, 1'b0, 16'h0000);
    sdtm_ctrl_model_inst.nop(2);
    #1;
    chk_word("mode after busy load", 16'h0223, {4'h0, mode});
    // Single-location writes on consecutive cycles; a burst would smear toggling data.
    for (int i = 0; i < 8; i++) begin
      mem[i] = 16'hA500 + 16'(i);
      sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_WR, 2'h0, 12'(i), 1'b0, 1'b1, mem[i]);
      #1;
      chk_flag("write ready", 1'b1, wbuf_rdy);
    end
    sdtm_ctrl_model_inst.close();
    sdtm_ctrl_model_inst.load(12'h02B);
    ilv = 1'b1;
    sdtm_ctrl_model_inst.open(2'h0, 12'h005);
    rd(2'h0, 3'h5, 2, 8, -1, -1, sdtm_pkg::CMD_NOP, 1'b0);
    sdtm_ctrl_model_inst.close();
    sdtm_ctrl_model_inst.load(12'h032);
    ilv = 1'b0;
    sdtm_ctrl_model_inst.open(2'h0, 12'h005);
    // Burst stop drops its own cycle's word; the mask drops word two of the next burst.
    mem[4] = 16'hC304;
    mem[5] = 16'hC305;
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_WR, 2'h0, 12'h004, 1'b0, 1'b1, 16'hC304);
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 16'hC305);
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_BST, 2'h0, 12'h000, 1'b0, 1'b1, 16'hC306);
    mem[0] = 16'hC300;
    mem[1] = 16'hC301;
    mem[3] = 16'hC303;
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_WR, 2'h0, 12'h000, 1'b0, 1'b1, 16'hC300);
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 16'hC301);
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1, 1'b1, 16'hC302);
    sdtm_ctrl_model_inst.cmd(sdtm_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 16'hC303);
    sdtm_ctrl_model_inst.nop(3);
    rd(2'h0, 3'h2, 3, 4, 0, -1, sdtm_pkg::CMD_NOP, 1'b0);
    rd(2'h0, 3'h4, 3, 4, -1, 1, sdtm_pkg::CMD_BST, 1'b0);
    rd(2'h0, 3'h0, 3, 4, -1, 0, sdtm_pkg::CMD_PRE, 1'b0);
    chk_flag("closed by precharge", 1'b0, bank_open[0]);
    sdtm_ctrl_model_inst.open(2'h0, 12'h005);
    rd(2'h0, 3'h0, 3, 4, -1, -1, sdtm_pkg::CMD_NOP, 1'b1);
    // A test operating mode must leave reads without any output.
    sdtm_ctrl_model_inst.load(12'h0B2);
    sdtm_ctrl_model_inst.open(2'h0, 12'h005);
    rd(2'h0, 3'h0, 3, 0, -1, -1, sdtm_pkg::CMD_NOP, 1'b0);
    sdtm_ctrl_model_inst.close();
    tally_and_finish();
  end

  // Whole run is about 13000 cycles; cut a hang well after that.
  initial begin
    #(8 * 20000);
    error_cnt++;
    $display("Error watchdog expected completion seen timeout");
    tally_and_finish();
  end
endmodule : sdram_timing_init_mode_tb
